// >>> word_mode_relative_address_gen.sv
// Word-mode address generation and operand/descriptor call sequencing
// Behaviour
// - Program level: reference base, positive 10-bit index
// - Index bit 0 off: reference base, max 511
// - Bit 0 on, bit 1 off: index max 255
// - That code, no mark stack: frame base
// - Mark stack on: fetch base+7, frame field
// - Bits 0,1 on, 2 off: program-word base
// - Store/release operators force reference base instead
// - Bits 0-2 on: negative index, frame base
// - Stack pointer addresses top; pushes go through it
// - Absolute access: low 15 top-of-stack bits
// - Chained access: bits 18-32 of fetched word
// - Operand call on operand/control word: push it
// - Operand call on descriptor: push target, flag check
// - Program descriptor: return word, branch; special pushed
// - Descriptor call on operand: push built descriptor
// - Descriptor call on descriptor: push it unchanged
// - Descriptor call on program descriptor: as operand call
// - Descriptor flag, type bit and presence bit
// - Bits 8-17 word count; zero means single
// - Integer and continuity bits; other bits zero
// - Bits 33-47 hold absolute core address
// - Base in nine high address bits plus index
// - Syllable type from bits 11 and 10
// - Subprogram flag enables extended base selections
`timescale 1ns/10ps
module word_mode_relative_address_gen (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_cmd_valid,
  input wire logic [1:0] i_cmd,
  input wire logic [wm_addr_pkg::SYL_W-1:0] i_syllable,
  input wire logic i_index_from_tos,
  input wire logic [wm_addr_pkg::WORD_W-1:0] i_tos_word,
  input wire logic i_subprogram_level_flag,
  input wire logic i_mark_stack_flag,
  input wire logic i_force_ref_base,
  input wire logic [wm_addr_pkg::RBASE_W-1:0] i_ref_base,
  input wire logic [wm_addr_pkg::ADDR_W-1:0] i_frame_base,
  input wire logic [wm_addr_pkg::ADDR_W-1:0] i_prog_word_addr,
  input wire logic i_stack_load,
  input wire logic [wm_addr_pkg::ADDR_W-1:0] i_stack_value,
  input wire logic i_mem_ack,
  input wire logic [wm_addr_pkg::WORD_W-1:0] i_mem_rdata,
  output logic o_busy,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [wm_addr_pkg::ADDR_W-1:0] o_mem_addr,
  output logic [wm_addr_pkg::WORD_W-1:0] o_mem_wdata,
  output logic [wm_addr_pkg::ADDR_W-1:0] o_stack_ptr,
  output logic o_push_valid,
  output logic [wm_addr_pkg::WORD_W-1:0] o_push_word,
  output logic o_operator_valid,
  output logic [wm_addr_pkg::IDX_W-1:0] o_operator_code,
  output logic o_branch,
  output logic [wm_addr_pkg::ADDR_W-1:0] o_branch_addr,
  output logic o_flag_bit_int,
  output logic o_presence_int
);
  import wm_addr_pkg::*;

  // Sequencer state, request snapshot, memory port and result pulses
  typedef struct packed {
    // Sequencer position
    wm_state_e st;
    logic busy;
    logic is_descriptor_call_syllable;
    logic raw;
    logic pre_done;
    // Request snapshot taken at acceptance, then saved frame field and last fetched word
    logic use_tos;
    logic force_r;
    logic subprogram_level_flag;
    logic mark_stack_flag;
    logic [IDX_W-1:0] syl_idx;
    logic [IDX_W-1:0] tos_idx;
    logic [ADDR_W-1:0] saved_f;
    logic [WORD_W-1:0] last_word;
    // Memory port and stack pointer
    logic [ADDR_W-1:0] m;
    logic [ADDR_W-1:0] s;
    logic mem_req;
    logic mem_we;
    logic [WORD_W-1:0] wdata;
    // One-cycle results
    logic push_valid;
    logic [WORD_W-1:0] push_word;
    logic op_valid;
    logic [IDX_W-1:0] op_code;
    logic branch;
    logic [ADDR_W-1:0] branch_addr;
    logic flag_int;
    logic pres_int;
  } wm_regs_s;

  // Idle, empty stack pointer, every pulse low
  localparam wm_regs_s REGS_RST = '{st: ST_IDLE, s: S_RST, default: '0};

  // Registered state and its next value
  wm_regs_s state_ff;
  wm_regs_s nxt_state;

  // Carrier to the address calculator
  rel_addr_if rel ();

  // Decoded syllable and fetched-word kind
  logic take_req;
  logic [1:0] syl_type;
  logic is_flagged;
  logic is_data_descriptor_call_syllable;
  logic is_prog_descriptor_call_syllable;
  logic is_special;
  logic [WORD_W-1:0] built_descriptor_call_syllable;
  logic [WORD_W-1:0] ret_word;

  // Index source and flags captured at acceptance
  assign rel.idx = state_ff.use_tos ? state_ff.tos_idx : state_ff.syl_idx;
  assign rel.subprogram_level_flag = state_ff.subprogram_level_flag;
  assign rel.mark_stack_flag = state_ff.mark_stack_flag;
  assign rel.force_r = state_ff.force_r;

  // Base registers read live during address calculation
  assign rel.r_base = i_ref_base;
  assign rel.f_base = i_frame_base;
  assign rel.c_base = i_prog_word_addr;
  assign rel.saved_f = state_ff.saved_f;

  // Base and index selection
  rel_addr_calc rel_addr_calc_i (
    .rel(rel.calc)
  );

  // Syllable type: bit 11 is index 0, bit 10 is index 1
  assign syl_type = i_syllable[1:0];

  // Request accepted only while idle and no stack load pending
  assign take_req = i_cmd_valid && !i_stack_load && state_ff.st == ST_IDLE;

  // Flag and type bits of the fetched word
  assign is_flagged = i_mem_rdata[FLAG_POS];
  assign is_data_descriptor_call_syllable = is_flagged && !i_mem_rdata[KIND_POS];

  // Program descriptor and its special variant
  assign is_prog_descriptor_call_syllable = is_flagged && i_mem_rdata[KIND_POS] && i_mem_rdata[PROG_POS];
  assign is_special = i_mem_rdata[SPECIAL_POS];

  // Descriptor for an operand: flag, present, single word, core address
  always_comb begin
    built_descriptor_call_syllable = WORD_ZERO;
    built_descriptor_call_syllable[FLAG_POS] = 1'b1;
    built_descriptor_call_syllable[KIND_POS] = 1'b0;
    built_descriptor_call_syllable[PRES_POS] = 1'b1;
    built_descriptor_call_syllable[CNT_HI:CNT_LO] = '0;
    built_descriptor_call_syllable[INT_POS] = 1'b0;
    built_descriptor_call_syllable[CONT_POS] = 1'b0;
    built_descriptor_call_syllable[CADDR_HI:CADDR_LO] = state_ff.m;
  end

  // Return word: control word holding frame and program-word address
  always_comb begin
    ret_word = WORD_ZERO;
    ret_word[FLAG_POS] = 1'b1;
    ret_word[KIND_POS] = 1'b1;
    ret_word[FADDR_HI:FADDR_LO] = i_frame_base;
    ret_word[CADDR_HI:CADDR_LO] = i_prog_word_addr;
  end

  // Next-state logic for the whole sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_state.push_valid = 1'b0;
    nxt_state.op_valid = 1'b0;
    nxt_state.branch = 1'b0;
    nxt_state.flag_int = 1'b0;
    nxt_state.pres_int = 1'b0;
    if (i_stack_load && state_ff.st == ST_IDLE) begin
      nxt_state.s = i_stack_value;
    end
    case (state_ff.st)
      // Snapshot of the request and dispatch by kind
      ST_IDLE: begin
        if (take_req) begin
          nxt_state.raw = 1'b0;
          nxt_state.pre_done = 1'b0;
          nxt_state.is_descriptor_call_syllable = (syl_type == SYL_DESCRIPTOR_CALL_SYLLABLE);
          nxt_state.use_tos = i_index_from_tos;
          nxt_state.force_r = i_force_ref_base;
          nxt_state.subprogram_level_flag = i_subprogram_level_flag;
          nxt_state.mark_stack_flag = i_mark_stack_flag;
          nxt_state.syl_idx = i_syllable[SYL_W-1:2];
          nxt_state.tos_idx = i_tos_word[IDX_W-1:0];
          // Absolute access from the top-of-stack word
          if (i_cmd == CMD_ABS) begin
            nxt_state.raw = 1'b1;
            nxt_state.m = i_tos_word[ADDR_W-1:0];
            nxt_state.mem_req = 1'b1;
            nxt_state.mem_we = 1'b0;
            nxt_state.busy = 1'b1;
            nxt_state.st = ST_MAIN;
          end else if (i_cmd == CMD_CHAIN) begin
            // Chained access through the last fetched word
            nxt_state.raw = 1'b1;
            nxt_state.m = state_ff.last_word[FADDR_HI:FADDR_LO];
            nxt_state.mem_req = 1'b1;
            nxt_state.mem_we = 1'b0;
            nxt_state.busy = 1'b1;
            nxt_state.st = ST_MAIN;
          end else if (i_cmd == CMD_SYL) begin
            // Literals push, operators report, calls form an address
            if (syl_type == SYL_LIT) begin
              nxt_state.wdata = WORD_ZERO;
              nxt_state.wdata[IDX_W-1:0] = i_syllable[SYL_W-1:2];
              nxt_state.mem_req = 1'b1;
              nxt_state.mem_we = 1'b1;
              nxt_state.m = state_ff.s + S_STEP;
              nxt_state.busy = 1'b1;
              nxt_state.st = ST_PUSH;
            end else if (syl_type == SYL_OPR) begin
              nxt_state.op_valid = 1'b1;
              nxt_state.op_code = i_syllable[SYL_W-1:2];
            end else begin
              nxt_state.busy = 1'b1;
              nxt_state.st = ST_CALC;
            end
          end
        end
      end

      // Preliminary fetch first when the saved frame is needed
      ST_CALC: begin
        nxt_state.mem_req = 1'b1;
        nxt_state.mem_we = 1'b0;
        if (rel.need_pre && !state_ff.pre_done) begin
          nxt_state.m = rel.pre_addr;
          nxt_state.st = ST_PRE;
        end else begin
          nxt_state.m = rel.addr;
          nxt_state.st = ST_MAIN;
        end
      end

      // Saved frame field latched before the main access
      ST_PRE: begin
        if (i_mem_ack) begin
          nxt_state.mem_req = 1'b0;
          nxt_state.saved_f = i_mem_rdata[FADDR_HI:FADDR_LO];
          nxt_state.pre_done = 1'b1;
          nxt_state.st = ST_CALC;
        end
      end

      // Main access; the fetched word kind decides what follows
      ST_MAIN: begin
        if (i_mem_ack) begin
          nxt_state.mem_req = 1'b1;
          nxt_state.last_word = i_mem_rdata;
          nxt_state.mem_we = 1'b1;
          nxt_state.wdata = i_mem_rdata;
          nxt_state.st = ST_PUSH;
          // Push, branch or indirect read by word kind
          if (state_ff.raw) begin
            nxt_state.wdata = i_mem_rdata;
          end else if (is_prog_descriptor_call_syllable && !is_special) begin
            nxt_state.wdata = ret_word;
            nxt_state.branch = 1'b1;
            nxt_state.branch_addr = i_mem_rdata[CADDR_HI:CADDR_LO];
            nxt_state.pres_int = !i_mem_rdata[PRES_POS];
          end else if (is_prog_descriptor_call_syllable) begin
            nxt_state.wdata = i_mem_rdata;
          end else if (is_data_descriptor_call_syllable && !state_ff.is_descriptor_call_syllable) begin
            nxt_state.mem_we = 1'b0;
            nxt_state.m = i_mem_rdata[CADDR_HI:CADDR_LO];
            nxt_state.pres_int = !i_mem_rdata[PRES_POS];
            nxt_state.st = ST_IND;
          end else if (is_data_descriptor_call_syllable) begin
            nxt_state.wdata = i_mem_rdata;
          end else if (state_ff.is_descriptor_call_syllable) begin
            nxt_state.wdata = built_descriptor_call_syllable;
          end else begin
            nxt_state.wdata = i_mem_rdata;
          end
          // Every push lands just above the stack top
          if (nxt_state.st == ST_PUSH) begin
            nxt_state.m = state_ff.s + S_STEP;
          end
        end
      end

      // Word behind a data descriptor, checked for its flag
      ST_IND: begin
        if (i_mem_ack) begin
          nxt_state.last_word = i_mem_rdata;
          nxt_state.wdata = i_mem_rdata;
          nxt_state.flag_int = is_flagged;
          nxt_state.mem_we = 1'b1;
          nxt_state.m = state_ff.s + S_STEP;
          nxt_state.st = ST_PUSH;
        end
      end

      // Push acknowledged: stack pointer steps, result reported
      ST_PUSH: begin
        if (i_mem_ack) begin
          nxt_state.mem_req = 1'b0;
          nxt_state.mem_we = 1'b0;
          nxt_state.s = state_ff.m;
          nxt_state.push_valid = 1'b1;
          nxt_state.push_word = state_ff.wdata;
          nxt_state.busy = 1'b0;
          nxt_state.st = ST_IDLE;
        end
      end

      // Unused codes fall back to the reset state
      default: begin
        nxt_state = REGS_RST;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff <= REGS_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Memory port straight from the state register
  assign o_busy = state_ff.busy;
  assign o_mem_req = state_ff.mem_req;
  assign o_mem_we = state_ff.mem_we;
  assign o_mem_addr = state_ff.m;
  assign o_mem_wdata = state_ff.wdata;

  // Stack pointer and push report
  assign o_stack_ptr = state_ff.s;
  assign o_push_valid = state_ff.push_valid;
  assign o_push_word = state_ff.push_word;

  // Operator, branch and interrupt pulses
  assign o_operator_valid = state_ff.op_valid;
  assign o_operator_code = state_ff.op_code;
  assign o_branch = state_ff.branch;
  assign o_branch_addr = state_ff.branch_addr;
  assign o_flag_bit_int = state_ff.flag_int;
  assign o_presence_int = state_ff.pres_int;
endmodule : word_mode_relative_address_gen

// >>> wm_addr_pkg.sv
// Shared widths, field positions, codes and state encoding for word-mode addressing
package wm_addr_pkg;
  localparam int WORD_W = 48;
  localparam int ADDR_W = 15;
  localparam int SYL_W = 12;
  localparam int RBASE_W = 9;
  localparam int IDX_W = 10;
  // Word bit n is vector index 47-n
  localparam int FLAG_POS = 47;
  localparam int KIND_POS = 46;
  localparam int PRES_POS = 45;
  localparam int PROG_POS = 44;
  localparam int SPECIAL_POS = 43;
  localparam int CNT_HI = 39;
  localparam int CNT_LO = 30;
  localparam int FADDR_HI = 29;
  localparam int FADDR_LO = 15;
  localparam int INT_POS = 28;
  localparam int CONT_POS = 27;
  localparam int CADDR_HI = 14;
  localparam int CADDR_LO = 0;
  localparam logic [ADDR_W-1:0] SAVED_IDX = 15'h0007;
  localparam logic [5:0] RBASE_PAD = 6'h00;
  localparam logic [ADDR_W-1:0] S_RST = 15'h0000;
  localparam logic [ADDR_W-1:0] S_STEP = 15'h0001;
  localparam logic [WORD_W-1:0] WORD_ZERO = 48'h0000_0000_0000;
  // Syllable type from the two low-order syllable bits
  localparam logic [1:0] SYL_LIT = 2'h0;
  localparam logic [1:0] SYL_OPR = 2'h1;
  localparam logic [1:0] SYL_OPERAND_CALL_SYLLABLE = 2'h2;
  localparam logic [1:0] SYL_DESCRIPTOR_CALL_SYLLABLE = 2'h3;
  // Request kinds accepted by the top module
  localparam logic [1:0] CMD_SYL = 2'h0;
  localparam logic [1:0] CMD_ABS = 2'h1;
  localparam logic [1:0] CMD_CHAIN = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CALC = 3'h1,
    ST_PRE = 3'h3,
    ST_MAIN = 3'h2,
    ST_IND = 3'h6,
    ST_PUSH = 3'h7
  } wm_state_e;
endpackage : wm_addr_pkg

// >>> rel_addr_if.sv
// Carrier between the sequencer and the relative address calculator
`timescale 1ns/10ps
interface rel_addr_if;
  import wm_addr_pkg::*;
  logic [IDX_W-1:0] idx;
  logic subprogram_level_flag;
  logic mark_stack_flag;
  logic force_r;
  logic [RBASE_W-1:0] r_base;
  logic [ADDR_W-1:0] f_base;
  logic [ADDR_W-1:0] c_base;
  logic [ADDR_W-1:0] saved_f;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] pre_addr;
  logic need_pre;
  modport seq (output idx, subprogram_level_flag, mark_stack_flag, force_r, r_base, f_base, c_base, saved_f,
               input addr, pre_addr, need_pre);
  modport calc (input idx, subprogram_level_flag, mark_stack_flag, force_r, r_base, f_base, c_base, saved_f,
                output addr, pre_addr, need_pre);
endinterface : rel_addr_if

// >>> rel_addr_calc.sv
// Base and index selection for relative addressing
`timescale 1ns/10ps
module rel_addr_calc (
  rel_addr_if.calc rel
);
  import wm_addr_pkg::*;

  logic [ADDR_W-1:0] r_abs;
  logic [ADDR_W-1:0] frame_base;

  // Reference base sits in the nine high-order address bits
  assign r_abs = {rel.r_base, RBASE_PAD};
  assign rel.pre_addr = r_abs + SAVED_IDX;
  assign frame_base = rel.mark_stack_flag ? rel.saved_f : rel.f_base;

  // Base, sign and index width chosen by the top index bits
  always_comb begin
    rel.need_pre = 1'b0;
    if (!rel.subprogram_level_flag) begin
      rel.addr = r_abs + ADDR_W'(rel.idx);
    end else if (!rel.idx[9]) begin
      rel.addr = r_abs + ADDR_W'(rel.idx[8:0]);
    end else if (!rel.idx[8]) begin
      rel.need_pre = rel.mark_stack_flag;
      rel.addr = frame_base + ADDR_W'(rel.idx[7:0]);
    end else if (!rel.idx[7]) begin
      if (rel.force_r) begin
        rel.addr = r_abs + ADDR_W'(rel.idx[6:0]);
      end else begin
        rel.addr = rel.c_base + ADDR_W'(rel.idx[6:0]);
      end
    end else begin
      rel.need_pre = rel.mark_stack_flag;
      rel.addr = frame_base - ADDR_W'(rel.idx[6:0]);
    end
  end
endmodule : rel_addr_calc

// >>> wm_addr_monitor.sv
// Checker of memory, stack and syllable behaviour at the top ports
`timescale 1ns/10ps
module wm_addr_monitor
  import wm_addr_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_cmd_valid,
  input wire logic [1:0] i_cmd,
  input wire logic [SYL_W-1:0] i_syllable,
  input wire logic i_index_from_tos,
  input wire logic [WORD_W-1:0] i_tos_word,
  input wire logic i_subprogram_level_flag,
  input wire logic [RBASE_W-1:0] i_ref_base,
  input wire logic i_stack_load,
  input wire logic [ADDR_W-1:0] i_stack_value,
  input wire logic i_mem_ack,
  input wire logic o_busy,
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic [ADDR_W-1:0] o_mem_addr,
  input wire logic [WORD_W-1:0] o_mem_wdata,
  input wire logic [ADDR_W-1:0] o_stack_ptr,
  input wire logic o_push_valid,
  input wire logic [WORD_W-1:0] o_push_word,
  input wire logic o_operator_valid,
  input wire logic [IDX_W-1:0] o_operator_code
);
  logic take;
  // Request accepted at this edge
  assign take = i_cmd_valid && !o_busy && !i_stack_load;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  AST_REQ_HOLD: assert property (
    o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we))
    else $error("memory request changed before ack");
  AST_IDLE_QUIET: assert property (!o_busy |-> !o_mem_req)
    else $error("memory request while idle");
  AST_PUSH_ADDR: assert property (
    o_mem_req && o_mem_we |-> o_mem_addr == o_stack_ptr + S_STEP)
    else $error("push not written above stack top");
  AST_PUSH_DATA: assert property (
    o_mem_req && o_mem_we && i_mem_ack |=> o_push_valid && o_push_word == $past(o_mem_wdata))
    else $error("push report wrong");
  AST_PUSH_ADVANCE: assert property (
    $rose(o_push_valid) |-> o_stack_ptr == $past(o_stack_ptr) + S_STEP)
    else $error("stack pointer did not advance");
  AST_STACK_LOAD: assert property (
    i_stack_load && !o_busy |=> o_stack_ptr == $past(i_stack_value))
    else $error("stack pointer load lost");
  AST_ABS_ADDR: assert property (
    take && i_cmd == CMD_ABS |=> o_mem_req && !o_mem_we && o_mem_addr == $past(i_tos_word[14:0]))
    else $error("absolute address wrong");
  AST_OPERATOR: assert property (
    take && i_cmd == CMD_SYL && i_syllable[1:0] == 2'h1
    |=> o_operator_valid && !o_busy && o_operator_code == $past(i_syllable[11:2]))
    else $error("operator not reported");
  AST_LITERAL: assert property (
    take && i_cmd == CMD_SYL && i_syllable[1:0] == 2'h0
    |=> o_mem_req && o_mem_we && o_mem_wdata == {38'h0, $past(i_syllable[11:2])})
    else $error("literal push wrong");
  AST_REL_PROGRAM: assert property (
    take && i_cmd == CMD_SYL && i_syllable[1:0] == 2'h2 && !i_subprogram_level_flag
    && !i_index_from_tos |-> ##2 o_mem_req && !o_mem_we
    && o_mem_addr == {$past(i_ref_base, 2), 6'h00} + 15'($past(i_syllable[11:2], 2)))
    else $error("program level relative address wrong");
endmodule : wm_addr_monitor

bind word_mode_relative_address_gen wm_addr_monitor wm_addr_monitor_i (.i_ref_clk, .i_sys_rst,
  .i_cmd_valid, .i_cmd, .i_syllable, .i_index_from_tos, .i_tos_word, .i_subprogram_level_flag,
  .i_ref_base, .i_stack_load, .i_stack_value, .i_mem_ack, .o_busy, .o_mem_req, .o_mem_we,
  .o_mem_addr, .o_mem_wdata, .o_stack_ptr, .o_push_valid, .o_push_word, .o_operator_valid,
  .o_operator_code);

// >>> wm_core_mem.sv
// Core memory partner answering read and write requests
`timescale 1ns/10ps
module wm_core_mem (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [wm_addr_pkg::ADDR_W-1:0] i_addr,
  input wire logic [wm_addr_pkg::WORD_W-1:0] i_wdata,
  input wire logic [3:0] i_delay,
  output logic o_ack,
  output logic [wm_addr_pkg::WORD_W-1:0] o_rdata
);
  import wm_addr_pkg::*;
  logic [WORD_W-1:0] mem [0:32767];
  logic [3:0] wait_cnt;
  // Answer after i_delay cycles; data line toggles when not answering
  always @(negedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ack <= 1'b0;
      wait_cnt <= 4'h0;
      o_rdata <= WORD_ZERO;
    end else if (!o_ack && i_req && wait_cnt >= i_delay) begin
      o_ack <= 1'b1;
      wait_cnt <= 4'h0;
      if (i_we) begin
        mem[i_addr] <= i_wdata;
      end else begin
        o_rdata <= mem[i_addr];
      end
    end else begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      if (!o_ack && i_req) begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : wm_core_mem

// >>> test_word_mode_relative_address_gen.sv
// Self-checking bench for word-mode address generation
`timescale 1ns/10ps
module test_word_mode_relative_address_gen;
  import wm_addr_pkg::*;
  logic i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_cmd_valid = 1'b0, i_index_from_tos = 1'b0;
  logic i_subprogram_level_flag = 1'b0, i_mark_stack_flag = 1'b0, i_force_ref_base = 1'b0;
  logic i_stack_load = 1'b0, i_mem_ack, o_busy, o_mem_req, o_mem_we, o_push_valid;
  logic o_operator_valid, o_branch, o_flag_bit_int, o_presence_int, saw_branch, saw_flag;
  logic [1:0] i_cmd = 2'h0;
  logic [11:0] i_syllable = 12'h000;
  logic [8:0] i_ref_base = 9'h005;
  logic [14:0] i_frame_base = 15'h0400, i_prog_word_addr = 15'h0800, i_stack_value = 15'h7000;
  logic [14:0] o_mem_addr, o_stack_ptr, o_branch_addr, br_addr, sp_exp, rd_addr;
  logic saw_pres;
  logic [47:0] i_tos_word = 48'h0, i_mem_rdata, o_mem_wdata, o_push_word;
  logic [9:0] o_operator_code;
  logic [3:0] mem_delay = 4'h0;
  int fail_count = 0, comparisons = 0;
  always #10 i_ref_clk = ~i_ref_clk;
  word_mode_relative_address_gen word_mode_relative_address_gen_i (.i_ref_clk, .i_sys_rst,
    .i_cmd_valid, .i_cmd, .i_syllable, .i_index_from_tos, .i_tos_word, .i_subprogram_level_flag,
    .i_mark_stack_flag, .i_force_ref_base, .i_ref_base, .i_frame_base, .i_prog_word_addr,
    .i_stack_load, .i_stack_value, .i_mem_ack, .i_mem_rdata, .o_busy, .o_mem_req, .o_mem_we,
    .o_mem_addr, .o_mem_wdata, .o_stack_ptr, .o_push_valid, .o_push_word, .o_operator_valid,
    .o_operator_code, .o_branch, .o_branch_addr, .o_flag_bit_int, .o_presence_int);
  wm_core_mem wm_core_mem_i (.i_ref_clk, .i_sys_rst, .i_req(o_mem_req), .i_we(o_mem_we),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_delay(mem_delay), .o_ack(i_mem_ack),
    .o_rdata(i_mem_rdata));
  task automatic check(input logic [47:0] seen, input logic [47:0] expd);
    comparisons++;
    if (seen !== expd) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expd);
    end
  endtask : check
  // Issue one request, follow it to its push, compare the pushed word
  task automatic run_cmd(input logic [1:0] cmd, input logic [11:0] syl, input logic [47:0] expd);
    int n;
    @(negedge i_ref_clk);
    i_cmd_valid = 1'b1;
    i_cmd = cmd;
    i_syllable = syl;
    @(negedge i_ref_clk);
    i_cmd_valid = 1'b0;
    saw_branch = 1'b0;
    saw_flag = 1'b0;
    saw_pres = 1'b0;
    n = 0;
    while (o_push_valid !== 1'b1 && n < 100) begin
      @(posedge i_ref_clk);
      #1;
      if (o_branch === 1'b1) begin
        saw_branch = 1'b1;
        br_addr = o_branch_addr;
      end
      if (o_flag_bit_int === 1'b1) saw_flag = 1'b1;
      if (o_presence_int === 1'b1) saw_pres = 1'b1;
      if (o_mem_req === 1'b1 && o_mem_we === 1'b0) rd_addr = o_mem_addr;
      n++;
    end
    sp_exp = sp_exp + 15'h0001;
    check(48'(o_push_valid), 48'h1);
    check(o_push_word, expd);
    check(48'(o_stack_ptr), 48'(sp_exp));
    check(wm_core_mem_i.mem[sp_exp], expd);
  endtask : run_cmd
  task automatic t_literal_operator();
    run_cmd(CMD_SYL, {10'h3FF, 2'b00}, 48'h0000_0000_03FF);
    @(negedge i_ref_clk);
    i_cmd_valid = 1'b1;
    i_syllable = {10'h155, 2'b01};
    @(negedge i_ref_clk);
    check(48'(o_operator_valid), 48'h1);
    check(48'(o_operator_code), 48'h155);
    check(48'(o_busy), 48'h0);
    i_cmd_valid = 1'b0;
    @(negedge i_ref_clk);
    check(48'(o_operator_valid), 48'h0);
    $display("literal and operator test done");
  endtask : t_literal_operator
  // Every base selection row, prompt and slow memory
  task automatic t_relative();
    logic [3:0] md [9] = '{4'h0, 4'h8, 4'h1, 4'h1, 4'h1, 4'h5, 4'h1, 4'h3, 4'h3};
    logic [9:0] fld [9] = '{10'h3FF, 10'h2A5, 10'h1FF, 10'h2FF, 10'h37F, 10'h37F, 10'h3FF,
      10'h2FF, 10'h3FF};
    logic [14:0] adr [9] = '{15'h053F, 15'h03E5, 15'h033F, 15'h04FF, 15'h087F, 15'h01BF,
      15'h0381, 15'h12FF, 15'h1181};
    logic [11:0] syl;
    logic [47:0] expw;
    wm_core_mem_i.mem[15'h0147] = {18'h0, 15'h1200, 15'h0000};
    for (int i = 0; i < 9; i++) begin
      expw = 48'h0000_0A00_0000 + 48'(adr[i]);
      syl = {md[i][3] ? 10'h000 : fld[i], 2'b10};
      wm_core_mem_i.mem[adr[i]] = expw;
      @(negedge i_ref_clk);
      mem_delay = 4'(i % 3);
      {i_index_from_tos, i_force_ref_base, i_mark_stack_flag, i_subprogram_level_flag} = md[i];
      i_tos_word = {38'h0, fld[i]};
      run_cmd(CMD_SYL, syl, expw);
      check(48'(rd_addr), 48'(adr[i]));
    end
    @(negedge i_ref_clk);
    {i_index_from_tos, i_force_ref_base, i_mark_stack_flag, i_subprogram_level_flag} = 4'h0;
    $display("relative addressing test done");
  endtask : t_relative
  task automatic t_calls();
    wm_core_mem_i.mem[15'h0141] = 48'hA000_0000_2000;
    wm_core_mem_i.mem[15'h2000] = 48'h0000_0000_5555;
    wm_core_mem_i.mem[15'h0142] = 48'h0000_0000_0077;
    wm_core_mem_i.mem[15'h0143] = 48'hF000_0000_3000;
    wm_core_mem_i.mem[15'h0144] = 48'hF800_0000_3000;
    run_cmd(CMD_SYL, {10'h001, 2'b10}, 48'h0000_0000_5555);
    check(48'(saw_flag), 48'h0);
    check(48'(saw_pres), 48'h0);
    wm_core_mem_i.mem[15'h2000] = 48'h8000_0000_0001;
    run_cmd(CMD_SYL, {10'h001, 2'b10}, 48'h8000_0000_0001);
    check(48'(saw_flag), 48'h1);
    wm_core_mem_i.mem[15'h0145] = 48'h8000_0000_2000;
    run_cmd(CMD_SYL, {10'h005, 2'b10}, 48'h8000_0000_0001);
    check(48'(saw_pres), 48'h1);
    run_cmd(CMD_SYL, {10'h002, 2'b11}, 48'hA000_0000_0142);
    run_cmd(CMD_SYL, {10'h001, 2'b11}, 48'hA000_0000_2000);
    for (int k = 0; k < 2; k++) begin
      run_cmd(CMD_SYL, {10'h003, 1'b1, 1'(k)}, 48'hC000_0200_0800);
      check(48'(saw_branch), 48'h1);
      check(48'(br_addr), 48'h3000);
    end
    run_cmd(CMD_SYL, {10'h004, 2'b10}, 48'hF800_0000_3000);
    check(48'(saw_branch), 48'h0);
    $display("call syllable test done");
  endtask : t_calls
  task automatic t_abs_chain();
    wm_core_mem_i.mem[15'h2100] = 48'h0000_1100_000F;
    wm_core_mem_i.mem[15'h2200] = 48'h0000_0000_BEEF;
    @(negedge i_ref_clk);
    mem_delay = 4'h2;
    i_tos_word = 48'hFFFF_0000_A100;
    run_cmd(CMD_ABS, 12'h000, 48'h0000_1100_000F);
    run_cmd(CMD_CHAIN, 12'h000, 48'h0000_0000_BEEF);
    $display("absolute and chained test done");
  endtask : t_abs_chain
  task automatic give_verdict();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_sys_rst = 1'b0;
    i_stack_load = 1'b1;
    @(negedge i_ref_clk);
    i_stack_load = 1'b0;
    sp_exp = 15'h7000;
    t_literal_operator();
    t_relative();
    t_calls();
    t_abs_chain();
    give_verdict();
  end
endmodule : test_word_mode_relative_address_gen
